/* File: hw/ems_params.svh */
// constants for the expander scan sequencer
`ifndef EMS_PARAMS_SVH
`define EMS_PARAMS_SVH
`define EMS_MUX_WAYS 4
`define EMS_BOX_STRIDE 64
`define EMS_MAX_BOXES 4
`define EMS_MAX_LIST 16
`define EMS_DIFF_MAX_CH 7
`define EMS_MUX_COUNTER 1
`endif

/* File: hw/ems_pkg.sv */
// types for the expander scan sequencer
package ems_pkg;
  typedef enum logic [2:0] {
    EMS_IDLE = 3'b001,
    EMS_RUN = 3'b010,
    EMS_DONE = 3'b100
  } ems_state_type;
endpackage

/* File: hw/ems_list_mem.sv */
// scan list memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ems_list_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [5:0] wr_data_i,
  // read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [5:0] rd_data_o
);
  logic [5:0] mem [DEPTH];
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

/* File: hw/ems_seq.sv */
// expander mux scan sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "ems_params.svh"
// Contract
// R01 - counter one dedicated to onboard mux stepping
// R02 - one box: four channels per entry
// R03 - two boxes: eight channels, A then B
// R04 - four boxes: sixteen channels per entry
// R05 - boxes visited A, B, C, D in order
// R06 - channel is 4n plus pos plus 64*box
// R07 - expander order fixed, only list varies
// R08 - onboard channels follow programmed list order
// R09 - differential lists hold channels 0..7 only
// R10 - host selects expander routing first
// R11 - sixteen 4:1 muxes per box, four boxes
// R12 - advance per strobe, wrap then next entry
module ems_seq #(
  parameter int LIST_DEPTH = `EMS_MAX_LIST,
  parameter int LIST_AW = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // configuration
  input wire logic [1:0] box_cfg_i,
  input wire logic diff_mode_i,
  input wire logic route_exp_i,
  // scan list load
  input wire logic list_wr_i,
  input wire logic [LIST_AW-1:0] list_addr_i,
  input wire logic [5:0] list_data_i,
  input wire logic [LIST_AW-1:0] list_len_m1_i,
  // scan control
  input wire logic start_i,
  input wire logic conv_strobe_i,
  // expander drive
  output logic [1:0] mux_pos_o,
  output logic [1:0] box_sel_o,
  output logic [7:0] exp_chan_o,
  output logic [3:0] onboard_chan_o,
  output logic onboard_step_o,
  output logic counter1_busy_o,
  output logic busy_o,
  output logic done_o,
  output logic list_err_o
);
  // ==========================================================
  // reset synchroniser
  logic rst_s1;
  logic rst_s2;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    ems_pkg::ems_state_type st;
    logic [1:0] pos;
    logic [1:0] box;
    logic [1:0] last_box;
    logic [LIST_AW-1:0] idx;
    logic [LIST_AW-1:0] last_idx;
    logic [3:0] onb;
    logic [7:0] chan;
    logic step;
    logic done;
    logic err;
    logic fetch;
    logic busy;
    logic ctr1;
  } ems_st_type;

  ems_st_type r;
  ems_st_type next_r;
  logic [5:0] list_q;

  // ==========================================================
  // scan list memory
  ems_list_mem #(
    .DEPTH(LIST_DEPTH),
    .AW(LIST_AW)
  ) u_list (
    .clk_i(clk_i),
    .wr_en_i(list_wr_i),
    .wr_addr_i(list_addr_i),
    .wr_data_i(list_data_i),
    .rd_addr_i(next_r.idx),
    .rd_data_o(list_q)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [1:0] nbox;
    nbox = 2'h0;

    // ========================================
    // defaults: hold state, pulses last one cycle
    next_r = r;
    next_r.step = 1'b0;
    next_r.done = 1'b0;
    unique case (r.st)
      ems_pkg::EMS_IDLE, ems_pkg::EMS_DONE: begin
        // ======================================
        // start decode, expander routing selected
        if (start_i && route_exp_i) begin // R10
          next_r.st = ems_pkg::EMS_RUN;
          next_r.busy = 1'b1;
          next_r.ctr1 = 1'b1; // R01
          next_r.idx = '0;
          next_r.last_idx = list_len_m1_i;
          next_r.pos = 2'h0;
          next_r.box = 2'h0;
          // ====================================
          // last box index from box count
          unique case (box_cfg_i) // R02 R03 R04
            2'h0: next_r.last_box = 2'h0;
            2'h1: next_r.last_box = 2'h1;
            default: next_r.last_box = 2'h3;
          endcase
          next_r.fetch = 1'b1;
          next_r.err = 1'b0;
        end
      end
      ems_pkg::EMS_RUN: begin
        // ======================================
        // list fetch: load entry, step counter one
        if (r.fetch) begin
          next_r.fetch = 1'b0;
          next_r.onb = list_q[3:0]; // R08
          next_r.step = 1'b1; // R01
          if (diff_mode_i && list_q > 6'(`EMS_DIFF_MAX_CH)) begin
            next_r.err = 1'b1; // R09
          end
        end else if (conv_strobe_i) begin // R12
          // ====================================
          // strobe stepping: position, then box
          if (r.pos != 2'h3) begin
            next_r.pos = r.pos + 2'h1; // R05 R07
          end else if (r.box != r.last_box) begin
            next_r.pos = 2'h0;
            next_r.box = r.box + 2'h1; // R05
          end else begin
            // ==================================
            // group wrap: next entry or done
            next_r.pos = 2'h0;
            next_r.box = 2'h0; // R12
            if (r.idx == r.last_idx) begin
              next_r.st = ems_pkg::EMS_DONE;
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
              next_r.ctr1 = 1'b0; // R01
            end else begin
              next_r.idx = r.idx + 1'b1; // R08
              next_r.fetch = 1'b1;
            end
          end
        end
      end
      default: begin
        next_r.st = ems_pkg::EMS_IDLE;
        next_r.busy = 1'b0;
        next_r.ctr1 = 1'b0;
      end
    endcase

    // ========================================
    // channel number: 64 per box, 4 per entry
    nbox = next_r.box;
    // R06 R11
    next_r.chan = {nbox, next_r.onb, next_r.pos};
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_s2) begin
    if (!rst_s2) begin
      r.st <= ems_pkg::EMS_IDLE;
      r.pos <= 2'h0;
      r.box <= 2'h0;
      r.last_box <= 2'h0;
      r.idx <= '0;
      r.last_idx <= '0;
      r.onb <= 4'h0;
      r.chan <= 8'h00;
      r.step <= 1'b0;
      r.done <= 1'b0;
      r.err <= 1'b0;
      r.fetch <= 1'b0;
      r.busy <= 1'b0;
      r.ctr1 <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    // select lines
    mux_pos_o = r.pos;
    box_sel_o = r.box;
    exp_chan_o = r.chan;
    onboard_chan_o = r.onb;
    // status
    onboard_step_o = r.step;
    counter1_busy_o = r.ctr1; // R01
    busy_o = r.busy;
    done_o = r.done;
    list_err_o = r.err;
  end
endmodule
`default_nettype wire

/* File: bench/ems_box_model.sv */
// model of the cascaded expander boxes
`timescale 1ns/1ps
`default_nettype none
module ems_box_model (
  // select lines
  input wire logic [1:0] box_sel_i,
  input wire logic [1:0] mux_pos_i,
  input wire logic [3:0] onboard_chan_i,
  // routed input
  output logic [7:0] routed_o
);
  // four boxes of sixteen 4:1 muxes, 64 inputs a box
  assign routed_o = {box_sel_i, onboard_chan_i, mux_pos_i};
endmodule
`default_nettype wire

/* File: bench/ems_seq_sva.sv */
// assertions for the expander scan sequencer
`timescale 1ns/1ps
`default_nettype none
module ems_seq_sva (
  // inputs
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic route_exp_i,
  input wire logic conv_strobe_i,
  // outputs
  input wire logic [1:0] mux_pos_o,
  input wire logic [1:0] box_sel_o,
  input wire logic [7:0] exp_chan_o,
  input wire logic [3:0] onboard_chan_o,
  input wire logic onboard_step_o,
  input wire logic counter1_busy_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_step_start: assert property (start_i && route_exp_i && !busy_o
    |-> ##2 onboard_step_o) else $error("step late");
  a_counter_own: assert property (counter1_busy_o == busy_o)
    else $error("counter not held");
  a_entry_base: assert property (onboard_step_o |-> mux_pos_o == 2'h0
    && box_sel_o == 2'h0) else $error("entry base");
  a_chan_map: assert property ($changed(exp_chan_o)
    |-> exp_chan_o == {box_sel_o, onboard_chan_o, mux_pos_o})
    else $error("bad channel");
  a_pos_order: assert property (busy_o && $changed(mux_pos_o)
    |-> mux_pos_o == $past(mux_pos_o) + 2'h1) else $error("pos order");
  a_box_order: assert property (busy_o && $changed(box_sel_o)
    |-> $past(mux_pos_o) == 2'h3) else $error("box order");
  a_pos_cause: assert property (busy_o && $changed(mux_pos_o)
    |-> $past(conv_strobe_i)) else $error("step without strobe");
  a_done_cause: assert property (done_o |-> !busy_o
    && $past(busy_o) && $past(conv_strobe_i)) else $error("done");
endmodule
bind ems_seq ems_seq_sva i_sva (.clk_i, .rstn_i, .start_i, .route_exp_i,
  .conv_strobe_i, .mux_pos_o, .box_sel_o, .exp_chan_o, .onboard_chan_o,
  .onboard_step_o, .counter1_busy_o, .busy_o, .done_o);
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the expander scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rstn_i = 1'b0, diff_mode_i = 1'b0, list_wr_i = 1'b0;
  logic start_i = 1'b0, conv_strobe_i = 1'b0, route_exp_i = 1'b1;
  logic [1:0] box_cfg_i = 2'h0, mux_pos_o, box_sel_o;
  logic [3:0] list_addr_i = 4'h0, list_len_m1_i = 4'h0, onboard_chan_o;
  logic [5:0] list_data_i = 6'h00;
  logic [7:0] exp_chan_o, routed;
  logic onboard_step_o, counter1_busy_o, busy_o, done_o, list_err_o;
  int miscompares = 0, comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  ems_seq i_dut (.clk_i, .rstn_i, .box_cfg_i, .diff_mode_i, .route_exp_i,
    .list_wr_i, .list_addr_i, .list_data_i, .list_len_m1_i, .start_i,
    .conv_strobe_i, .mux_pos_o, .box_sel_o, .exp_chan_o, .onboard_chan_o,
    .onboard_step_o, .counter1_busy_o, .busy_o, .done_o, .list_err_o);
  ems_box_model i_box (.box_sel_i(box_sel_o), .mux_pos_i(mux_pos_o),
    .onboard_chan_i(onboard_chan_o), .routed_o(routed));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic go(input logic [1:0] c, input logic [5:0] l [4], int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      list_wr_i <= 1'b1;
      list_addr_i <= 4'(i);
      list_data_i <= l[i];
    end
    @(posedge clk_i);
    list_wr_i <= 1'b0;
    box_cfg_i <= c;
    list_len_m1_i <= 4'(n - 1);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
  endtask
  task automatic scan(input logic [1:0] c, input logic [5:0] l [4], int n);
    logic [7:0] w;
    go(c, l, n);
    for (int e = 0; e < n; e++) begin
      for (int i = 0; i < 20 && onboard_step_o !== 1'b1; i++) begin
        @(posedge clk_i);
        #1;
      end
      chk({6'h00, onboard_step_o, counter1_busy_o}, 8'h03);
      for (int k = 0; k < 4 << (c == 2'h0 ? 0 : c == 2'h1 ? 1 : 2); k++) begin
        w = 8'(64 * (k / 4) + 4 * l[e] + k % 4);
        chk(exp_chan_o, w);
        chk(routed, w);
        @(posedge clk_i);
        conv_strobe_i <= 1'b1;
        @(posedge clk_i);
        conv_strobe_i <= 1'b0;
        #1;
      end
    end
    chk({6'h00, busy_o, done_o}, 8'h01);
    chk({7'h00, list_err_o}, 8'h00);
  endtask
  task automatic t_one_box;
    scan(2'h0, '{6'h05, 6'h00, 6'h0F, 6'h03}, 4);
    $display("one box test ended");
  endtask
  task automatic t_multi_box;
    scan(2'h1, '{6'h07, 6'h01, 6'h00, 6'h00}, 2);
    scan(2'h2, '{6'h0E, 6'h02, 6'h00, 6'h00}, 2);
    scan(2'h3, '{6'h09, 6'h00, 6'h00, 6'h00}, 1);
    $display("multi box test ended");
  endtask
  task automatic t_route_gate;
    @(posedge clk_i);
    route_exp_i <= 1'b0;
    go(2'h0, '{6'h03, 6'h00, 6'h00, 6'h00}, 1);
    chk({7'h00, busy_o}, 8'h00);
    @(posedge clk_i);
    #1;
    chk({7'h00, onboard_step_o}, 8'h00);
    @(posedge clk_i);
    route_exp_i <= 1'b1;
    $display("route test ended");
  endtask
  task automatic t_mid_reset;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    diff_mode_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({4'h0, busy_o, counter1_busy_o, done_o, list_err_o}, 8'h00);
    chk(exp_chan_o, 8'h00);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({mux_pos_o, box_sel_o, onboard_chan_o}, 8'h00);
    chk({6'h00, busy_o, onboard_step_o}, 8'h00);
    scan(2'h1, '{6'h06, 6'h00, 6'h00, 6'h00}, 1);
    $display("reset test ended");
  endtask
  task automatic t_diff_err;
    @(posedge clk_i);
    diff_mode_i <= 1'b1;
    scan(2'h0, '{6'h07, 6'h02, 6'h00, 6'h00}, 2);
    go(2'h0, '{6'h09, 6'h00, 6'h00, 6'h00}, 1);
    repeat (6) @(posedge clk_i);
    #1;
    chk({7'h0, list_err_o}, 8'h1);
    $display("diff test ended");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_one_box;
    t_multi_box;
    t_route_gate;
    t_diff_err;
    t_mid_reset;
    give_verdict;
  end
  initial begin
    #20000;
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
